// *** rtl/teg_consts.svh ***
// numeric constants for the trace element generator
`ifndef TEG_CONSTS_SVH
`define TEG_CONSTS_SVH
`define TEG_ADDR_W 64
`define TEG_DEPTH_W 8
`define TEG_CC_W 12
`define TEG_NO_SPEC_FIELD 8'h00
`define TEG_MAX_SPEC 8'h10
`define TEG_EXC_IRQ 4'h0
`define TEG_EXC_FIQ 4'h1
`define TEG_EXC_TRAP 4'h2
`define TEG_EXC_CALL 4'h3
`define TEG_EXC_IFLT 4'h4
`define TEG_EXC_DFLT 4'h5
`define TEG_EXC_IDBG 4'h6
`define TEG_EXC_DDBG 4'h7
`define TEG_EXC_ALIGN 4'h8
`define TEG_EXC_SERR 4'h9
`define TEG_EXC_HALT 4'ha
`define TEG_EXC_TXFAIL 4'hf
`define TEG_K_INFO 3'h0
`define TEG_K_ATOM_E 3'h1
`define TEG_K_ATOM_N 3'h2
`define TEG_K_EXC 3'h3
`define TEG_K_TXSTART 3'h4
`define TEG_K_TXCOMMIT 3'h5
`define TEG_K_COMMIT 3'h6
`define TEG_K_CANCEL 3'h7
`define TEG_R_ATOM 3'h0
`define TEG_R_EXC 3'h1
`define TEG_R_TXSTART 3'h2
`define TEG_R_TXCOMMIT 3'h3
`define TEG_R_TXFAIL 3'h4
`define TEG_R_COMMIT 3'h5
`define TEG_R_CANCEL 3'h6
`define TEG_ISA_64 2'h0
`define TEG_ISA_32F 2'h1
`define TEG_ISA_32C 2'h2
`endif

// *** rtl/teg_pkg.sv ***
// types shared by the trace element generator modules
`include "teg_consts.svh"
package teg_pkg;
	typedef enum logic [3:0] {
		EXC_IRQ = `TEG_EXC_IRQ,
		EXC_FIQ = `TEG_EXC_FIQ,
		EXC_TRAP = `TEG_EXC_TRAP,
		EXC_CALL = `TEG_EXC_CALL,
		EXC_IFLT = `TEG_EXC_IFLT,
		EXC_DFLT = `TEG_EXC_DFLT,
		EXC_IDBG = `TEG_EXC_IDBG,
		EXC_DDBG = `TEG_EXC_DDBG,
		EXC_ALIGN = `TEG_EXC_ALIGN,
		EXC_SERR = `TEG_EXC_SERR,
		EXC_HALT = `TEG_EXC_HALT,
		EXC_TXFAIL = `TEG_EXC_TXFAIL
	} exc_t;
	typedef enum logic [2:0] {
		K_INFO = `TEG_K_INFO,
		K_ATOM_E = `TEG_K_ATOM_E,
		K_ATOM_N = `TEG_K_ATOM_N,
		K_EXC = `TEG_K_EXC,
		K_TXSTART = `TEG_K_TXSTART,
		K_TXCOMMIT = `TEG_K_TXCOMMIT,
		K_COMMIT = `TEG_K_COMMIT,
		K_CANCEL = `TEG_K_CANCEL
	} elem_kind_t;
	typedef enum logic [2:0] {
		REQ_ATOM = `TEG_R_ATOM,
		REQ_EXC = `TEG_R_EXC,
		REQ_TXSTART = `TEG_R_TXSTART,
		REQ_TXCOMMIT = `TEG_R_TXCOMMIT,
		REQ_TXFAIL = `TEG_R_TXFAIL,
		REQ_COMMIT = `TEG_R_COMMIT,
		REQ_CANCEL = `TEG_R_CANCEL
	} req_t;
	typedef enum logic [1:0] {
		ISA_64 = `TEG_ISA_64,
		ISA_32F = `TEG_ISA_32F,
		ISA_32C = `TEG_ISA_32C
	} isa_t;
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_SYNC = 2'b01,
		ST_RUN = 2'b10
	} state_t;
	typedef struct packed {
		elem_kind_t kind;
		exc_t exc_type;
		isa_t isa;
		logic [`TEG_ADDR_W-1:0] addr;
		logic [`TEG_DEPTH_W-1:0] count;
		logic cc_en;
		logic [`TEG_CC_W-1:0] cc_thr;
		logic tx;
	} elem_t;
endpackage : teg_pkg

// *** rtl/teg_if.sv ***
// carrier between the core, the speculation counter and the address picker
`timescale 1ns/1ps
`include "teg_consts.svh"
interface teg_if
	import teg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn
);
	logic p0_push;
	logic [`TEG_DEPTH_W-1:0] resolve_n;
	logic [`TEG_DEPTH_W-1:0] depth;
	exc_t exc_type;
	logic imprecise;
	logic halt_low_sel;
	logic [`TEG_ADDR_W-1:0] pc;
	logic [`TEG_ADDR_W-1:0] next_pc;
	logic [`TEG_ADDR_W-1:0] exc_link;
	logic [`TEG_ADDR_W-1:0] halt_link;
	logic [`TEG_ADDR_W-1:0] halt_link_low;
	logic [`TEG_ADDR_W-1:0] ret_addr;
	modport core (output p0_push, resolve_n, exc_type, imprecise, halt_low_sel,
		pc, next_pc, exc_link, halt_link, halt_link_low, input depth, ret_addr);
	modport spec (input clk, resetn, p0_push, resolve_n, output depth);
	modport ret (input clk, resetn, exc_type, imprecise, halt_low_sel, pc, next_pc,
		exc_link, halt_link, halt_link_low, output ret_addr);
endinterface : teg_if

// *** rtl/spec_tracker.sv ***
// count of traced P0 elements not yet committed or cancelled
`timescale 1ns/1ps
`include "teg_consts.svh"
module spec_tracker
	import teg_pkg::*;
(
	teg_if.spec bus
);
	typedef struct packed {
		logic [`TEG_DEPTH_W-1:0] depth;
	} spec_state_t;
	spec_state_t cur;
	spec_state_t next_cur;
	logic [`TEG_DEPTH_W:0] sum;

	always_comb begin
		sum = {1'b0, cur.depth} + {{`TEG_DEPTH_W{1'b0}}, bus.p0_push};
		next_cur = cur;
		// a resolve beyond what is pending empties the count instead of wrapping
		if ({1'b0, bus.resolve_n} >= sum) begin
			next_cur.depth = '0;
		end else if (sum[`TEG_DEPTH_W]) begin
			next_cur.depth = '1;
		end else begin
			next_cur.depth = sum[`TEG_DEPTH_W-1:0] - bus.resolve_n;
		end
	end

	always_ff @(posedge bus.clk or negedge bus.resetn) begin
		if (!bus.resetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign bus.depth = cur.depth;

	push_inc_a: assert property (@(posedge bus.clk) disable iff (!bus.resetn)
		bus.p0_push && bus.resolve_n == '0 && cur.depth != '1
		|=> cur.depth == $past(cur.depth) + 8'h01)
		else $error("pending count did not grow on a P0 element");
	resolve_dec_a: assert property (@(posedge bus.clk) disable iff (!bus.resetn)
		!bus.p0_push && bus.resolve_n != '0 && bus.resolve_n <= cur.depth
		|=> cur.depth == $past(cur.depth) - $past(bus.resolve_n))
		else $error("pending count did not drop on resolve");
endmodule : spec_tracker

// *** rtl/ret_addr_sel.sv ***
// picks the preferred return address for an exception element
`timescale 1ns/1ps
`include "teg_consts.svh"
module ret_addr_sel
	import teg_pkg::*;
(
	teg_if.ret bus
);
	always_comb begin
		case (bus.exc_type)
			EXC_IRQ, EXC_FIQ: begin
				bus.ret_addr = bus.next_pc;
			end
			EXC_SERR: begin
				// imprecise errors cannot name the point of interruption
				bus.ret_addr = bus.imprecise ? bus.exc_link : bus.next_pc;
			end
			EXC_TRAP: begin
				bus.ret_addr = bus.pc;
			end
			EXC_CALL: begin
				bus.ret_addr = bus.next_pc;
			end
			EXC_IFLT, EXC_DFLT, EXC_IDBG, EXC_DDBG, EXC_ALIGN: begin
				bus.ret_addr = bus.pc;
			end
			EXC_HALT: begin
				if (bus.imprecise) begin
					bus.ret_addr = bus.halt_low_sel ? bus.halt_link_low : bus.halt_link;
				end else begin
					bus.ret_addr = bus.next_pc;
				end
			end
			default: begin
				bus.ret_addr = bus.pc;
			end
		endcase
	end

	trap_addr_a: assert property (@(posedge bus.clk) disable iff (!bus.resetn)
		bus.exc_type == EXC_TRAP |-> bus.ret_addr == bus.pc)
		else $error("trap return address is not the instruction");
	fault_addr_a: assert property (@(posedge bus.clk) disable iff (!bus.resetn)
		bus.exc_type inside {EXC_IFLT, EXC_DFLT, EXC_ALIGN} |-> bus.ret_addr == bus.pc)
		else $error("fault return address is not the instruction");
	serr_link_a: assert property (@(posedge bus.clk) disable iff (!bus.resetn)
		bus.exc_type == EXC_SERR && bus.imprecise |-> bus.ret_addr == bus.exc_link)
		else $error("imprecise error address is not the link value");
	halt_link_a: assert property (@(posedge bus.clk) disable iff (!bus.resetn)
		bus.exc_type == EXC_HALT && bus.imprecise && !bus.halt_low_sel
		|-> bus.ret_addr == bus.halt_link)
		else $error("imprecise halt address is not the halt link");
endmodule : ret_addr_sel

// *** rtl/trace_element_generator.sv ***
// trace element generator: request decode, element register, sync control
`timescale 1ns/1ps
//------------------------------------------------------------
//------------------------------------------------------------
`include "teg_consts.svh"
module trace_element_generator
	import teg_pkg::*;
#(
	parameter bit SPEC_IMPL = 1'b1,
	parameter logic [`TEG_DEPTH_W-1:0] MAX_SPEC = `TEG_MAX_SPEC,
	parameter bit TX_START_P0 = 1'b0
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic trace_enable_in,
	input wire logic buffer_overflow_in,
	input wire logic prohibited_in,
	input wire logic in_tx_in,
	input wire logic cc_enable_in,
	input wire logic [`TEG_CC_W-1:0] cc_threshold_in,
	input wire logic req_valid_in,
	input wire req_t req_kind_in,
	input wire logic req_taken_in,
	input wire exc_t req_exc_type_in,
	input wire logic req_imprecise_in,
	input wire logic req_halt_low_in,
	input wire isa_t req_isa_in,
	input wire logic [`TEG_ADDR_W-1:0] req_pc_in,
	input wire logic [`TEG_ADDR_W-1:0] req_next_pc_in,
	input wire logic [`TEG_ADDR_W-1:0] exc_link_in,
	input wire logic [`TEG_ADDR_W-1:0] halt_link_in,
	input wire logic [`TEG_ADDR_W-1:0] halt_link_low_in,
	input wire logic [`TEG_DEPTH_W-1:0] req_count_in,
	output logic req_ready_out,
	input wire logic elem_ready_in,
	output logic elem_valid_out,
	output elem_kind_t elem_kind_out,
	output exc_t elem_exc_type_out,
	output isa_t elem_isa_out,
	output logic [`TEG_ADDR_W-1:0] elem_addr_out,
	output logic [`TEG_DEPTH_W-1:0] elem_count_out,
	output logic elem_cc_en_out,
	output logic [`TEG_CC_W-1:0] elem_cc_thr_out,
	output logic elem_tx_out,
	output logic [`TEG_DEPTH_W-1:0] spec_depth_out,
	output logic tracing_out,
	output logic [`TEG_DEPTH_W-1:0] max_speculation_depth_field_out,
	output logic transaction_start_is_p0_flag_out
);
	typedef struct packed {
		state_t st;
		logic vld;
		logic tx;
		logic seen;
		elem_t el;
	} core_t;

	core_t cur;
	core_t next_cur;
	logic slot;
	logic abort;
	logic take;
	logic start_p0;

	teg_if bus (
		.clk(clk_in),
		.resetn(resetn_in)
	);

	spec_tracker u_spec (
		.bus(bus)
	);

	ret_addr_sel u_ret (
		.bus(bus)
	);

	//------------------------------------------------------------
	// element builder
	//------------------------------------------------------------
	function automatic elem_t mk(
		input elem_kind_t k,
		input exc_t e,
		input isa_t i,
		input logic [`TEG_ADDR_W-1:0] a,
		input logic [`TEG_DEPTH_W-1:0] c
	);
		elem_t r;
		r = '0;
		r.kind = k;
		r.exc_type = e;
		r.isa = i;
		r.addr = a;
		r.count = c;
		return r;
	endfunction : mk

	//------------------------------------------------------------
	// identification fields
	//------------------------------------------------------------
	assign max_speculation_depth_field_out = SPEC_IMPL ? MAX_SPEC : `TEG_NO_SPEC_FIELD;
	assign start_p0 = !SPEC_IMPL || TX_START_P0;
	assign transaction_start_is_p0_flag_out = start_p0;

	//------------------------------------------------------------
	// handshakes
	//------------------------------------------------------------
	// one element register: a new element may load as the old one leaves
	assign slot = !cur.vld || elem_ready_in;
	assign abort = cur.tx && (!trace_enable_in || buffer_overflow_in || prohibited_in);
	// requests stall while tracing is off, lost or filtered
	assign req_ready_out = cur.st == ST_RUN && slot && !abort && trace_enable_in
		&& !buffer_overflow_in && !prohibited_in;
	assign take = req_valid_in && req_ready_out;

	assign bus.exc_type = req_exc_type_in;
	assign bus.imprecise = req_imprecise_in;
	assign bus.halt_low_sel = req_halt_low_in;
	assign bus.pc = req_pc_in;
	assign bus.next_pc = req_next_pc_in;
	assign bus.exc_link = exc_link_in;
	assign bus.halt_link = halt_link_in;
	assign bus.halt_link_low = halt_link_low_in;

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		bus.p0_push = 1'b0;
		bus.resolve_n = '0;
		if (cur.vld && elem_ready_in) begin
			next_cur.vld = 1'b0;
			next_cur.seen = 1'b1;
		end
		case (cur.st)
			ST_OFF: begin
				if (trace_enable_in) begin
					next_cur.st = ST_SYNC;
				end
			end
			ST_SYNC: begin
				if (!trace_enable_in) begin
					next_cur.st = ST_OFF;
				end else if (slot) begin
					next_cur.vld = 1'b1;
					next_cur.el = mk(K_INFO, EXC_IRQ, ISA_64, '0, bus.depth);
					next_cur.el.cc_en = cc_enable_in;
					next_cur.el.cc_thr = cc_threshold_in;
					next_cur.el.tx = cur.tx;
					next_cur.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (abort) begin
					// outcome is unknown here, so only a failure can be claimed
					if (slot) begin
						next_cur.vld = 1'b1;
						next_cur.el = mk(K_EXC, EXC_TXFAIL, req_isa_in, req_pc_in, '0);
						next_cur.tx = 1'b0;
						bus.p0_push = 1'b1;
					end
				end else if (!trace_enable_in) begin
					next_cur.st = ST_OFF;
				end else if (take) begin
					next_cur.vld = 1'b1;
					case (req_kind_in)
						REQ_ATOM: begin
							if (req_taken_in) begin
								next_cur.el = mk(K_ATOM_E, EXC_IRQ, req_isa_in, req_pc_in, '0);
							end else begin
								next_cur.el = mk(K_ATOM_N, EXC_IRQ, req_isa_in, req_pc_in, '0);
							end
							bus.p0_push = 1'b1;
							if (in_tx_in) begin
								next_cur.tx = 1'b1;
							end
						end
						REQ_EXC: begin
							next_cur.el = mk(K_EXC, req_exc_type_in, req_isa_in,
								bus.ret_addr, '0);
							bus.p0_push = 1'b1;
						end
						REQ_TXSTART: begin
							next_cur.el = mk(K_TXSTART, EXC_IRQ, req_isa_in, req_pc_in, '0);
							next_cur.tx = 1'b1;
							bus.p0_push = start_p0;
						end
						REQ_TXCOMMIT: begin
							next_cur.el = mk(K_TXCOMMIT, EXC_IRQ, req_isa_in, req_pc_in, '0);
							next_cur.tx = 1'b0;
						end
						REQ_TXFAIL: begin
							next_cur.el = mk(K_EXC, EXC_TXFAIL, req_isa_in, req_pc_in, '0);
							next_cur.tx = 1'b0;
							bus.p0_push = 1'b1;
						end
						REQ_COMMIT: begin
							next_cur.el = mk(K_COMMIT, EXC_IRQ, ISA_64, '0, req_count_in);
							bus.resolve_n = req_count_in;
						end
						REQ_CANCEL: begin
							next_cur.el = mk(K_CANCEL, EXC_IRQ, ISA_64, '0, req_count_in);
							bus.resolve_n = req_count_in;
						end
						default: begin
							next_cur.vld = cur.vld && !elem_ready_in;
						end
					endcase
				end
			end
			default: begin
				next_cur.st = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	assign elem_valid_out = cur.vld;
	assign elem_kind_out = cur.el.kind;
	assign elem_exc_type_out = cur.el.exc_type;
	assign elem_isa_out = cur.el.isa;
	assign elem_addr_out = cur.el.addr;
	assign elem_count_out = cur.el.count;
	assign elem_cc_en_out = cur.el.cc_en;
	assign elem_cc_thr_out = cur.el.cc_thr;
	assign elem_tx_out = cur.el.tx;
	assign spec_depth_out = bus.depth;
	assign tracing_out = cur.st == ST_RUN;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence req_acc_s;
		req_valid_in && req_ready_out;
	endsequence
	sequence out_wait_s;
		elem_valid_out && !elem_ready_in;
	endsequence

	hold_stable_a: assert property (out_wait_s |=> elem_valid_out
		&& $stable(elem_kind_out) && $stable(elem_addr_out) && $stable(elem_count_out))
		else $error("element changed before it was taken");
	info_first_a: assert property (elem_valid_out && !cur.seen
		|-> elem_kind_out == K_INFO)
		else $error("first element is not an info element");
	info_body_a: assert property (cur.st == ST_SYNC && trace_enable_in && slot
		|=> elem_valid_out && elem_kind_out == K_INFO
		&& elem_count_out == $past(bus.depth) && elem_cc_thr_out == $past(cc_threshold_in))
		else $error("info element content wrong");
	abort_fail_a: assert property (cur.st == ST_RUN && cur.tx && !trace_enable_in && slot
		|=> elem_kind_out == K_EXC && elem_exc_type_out == EXC_TXFAIL && !cur.tx)
		else $error("no failure element on disable inside transaction");
	atom_not_a: assert property (req_acc_s ##0 req_kind_in == REQ_ATOM && !req_taken_in
		|=> elem_valid_out && elem_kind_out == K_ATOM_N)
		else $error("not taken branch gave wrong atom");
	irq_addr_a: assert property (req_acc_s ##0 req_kind_in == REQ_EXC
		&& req_exc_type_in == EXC_IRQ |=> elem_addr_out == $past(req_next_pc_in))
		else $error("interrupt return address wrong");
	call_addr_a: assert property (req_acc_s ##0 req_kind_in == REQ_EXC
		&& req_exc_type_in == EXC_CALL |=> elem_kind_out == K_EXC
		&& elem_addr_out == $past(req_next_pc_in) && elem_isa_out == $past(req_isa_in))
		else $error("call return address wrong");
	exc_p0_a: assert property (req_acc_s ##0 req_kind_in == REQ_EXC
		|-> bus.p0_push)
		else $error("exception element not counted as P0");
	no_spec_a: assert property (!SPEC_IMPL
		|-> max_speculation_depth_field_out == `TEG_NO_SPEC_FIELD
		&& transaction_start_is_p0_flag_out)
		else $error("speculation fields wrong without speculation");

	//------------------------------------------------------------
	// transfer checks
	//------------------------------------------------------------
	atom_taken_a: assert property (req_acc_s ##0 req_kind_in == REQ_ATOM && req_taken_in
		|=> elem_valid_out && elem_kind_out == K_ATOM_E)
		else $error("taken branch gave wrong atom");
	tx_mark_a: assert property (req_acc_s ##0 req_kind_in == REQ_ATOM && in_tx_in
		|=> cur.tx)
		else $error("transactional atom did not open a transaction");
	// trace lost inside a transaction: a failure is the only safe claim
	abort_lost_a: assert property (cur.st == ST_RUN && cur.tx && slot
		&& (buffer_overflow_in || prohibited_in)
		|=> elem_kind_out == K_EXC && elem_exc_type_out == EXC_TXFAIL && !cur.tx)
		else $error("no failure element on overflow or prohibited entry");
	lost_refuse_a: assert property (buffer_overflow_in || prohibited_in
		|-> !req_ready_out)
		else $error("request taken while trace is lost");
	one_per_req_a: assert property (req_acc_s |=> elem_valid_out)
		else $error("accepted request gave no element");
	drain_a: assert property (cur.st == ST_RUN && !abort && !req_valid_in
		&& elem_valid_out && elem_ready_in |=> !elem_valid_out)
		else $error("element repeated after it was taken");
	count_copy_a: assert property (req_acc_s ##0 req_kind_in inside {REQ_COMMIT, REQ_CANCEL}
		|=> elem_count_out == $past(req_count_in))
		else $error("resolve element count wrong");
	exc_isa_a: assert property (req_acc_s ##0 req_kind_in == REQ_EXC
		|=> elem_isa_out == $past(req_isa_in) && elem_exc_type_out == $past(req_exc_type_in))
		else $error("exception element set or type wrong");
	ready_run_a: assert property (cur.st != ST_RUN |-> !req_ready_out)
		else $error("request taken outside tracing");
	start_p0_a: assert property (req_acc_s ##0 req_kind_in == REQ_TXSTART
		|-> bus.p0_push == transaction_start_is_p0_flag_out)
		else $error("transaction start P0 counting wrong");
endmodule : trace_element_generator

// *** testbench/pe_model.sv ***
// processing element model: issues trace requests with a held handshake
`timescale 1ns/1ps
module core_model
	import teg_pkg::*;
#(
	parameter logic [63:0] PC = 64'h1000,
	parameter logic [63:0] NPC = 64'h1004
) (
	input wire logic clk_in,
	input wire logic ready_in,
	output logic valid_out,
	output req_t kind_out,
	output logic taken_out,
	output exc_t exc_out,
	output logic imp_out,
	output logic low_out,
	output isa_t isa_out,
	output logic [63:0] pc_out,
	output logic [63:0] npc_out,
	output logic [7:0] n_out
);
	initial begin
		{valid_out, taken_out, imp_out, low_out, pc_out, npc_out, n_out} = '0;
		kind_out = REQ_ATOM;
		exc_out = EXC_IRQ;
		isa_out = ISA_64;
	end
	// request held from a falling edge until ready is seen 1 ns after a falling edge, then through the next rising edge
	task automatic issue(input req_t k, input exc_t e, input logic imp, input logic low,
		input isa_t i, input logic tk, input logic [7:0] n);
		@(negedge clk_in);
		valid_out = 1'b1;
		kind_out = k;
		exc_out = e;
		imp_out = imp;
		low_out = low;
		isa_out = i;
		taken_out = tk;
		n_out = n;
		pc_out = PC;
		npc_out = NPC;
		#1;
		while (!ready_in) begin
			@(negedge clk_in);
			#1;
		end
		@(posedge clk_in);
	endtask : issue
	// released address, count and taken lines flip so stale values cannot pass for good ones
	task automatic idle();
		@(negedge clk_in);
		valid_out = 1'b0;
		pc_out = ~pc_out;
		npc_out = ~npc_out;
		n_out = ~n_out;
		taken_out = ~taken_out;
	endtask : idle
endmodule : core_model

// *** testbench/trace_element_generator_tb.sv ***
// self-checking bench for the trace element generator
`timescale 1ns/1ps
module trace_element_generator_tb;
	import teg_pkg::*;
	localparam logic [63:0] PC = 64'h1000;
	localparam logic [63:0] NPC = 64'h1004;
	localparam logic [63:0] XLINK = 64'h2000;
	localparam logic [63:0] HL = 64'h3000;
	localparam logic [63:0] HLL = 64'h4000;
	typedef struct {req_t k; exc_t e; logic imp; logic low; isa_t i; logic tk;
		logic [7:0] n; elem_kind_t ek; logic [63:0] ea;} row_t;
	logic clk_in = 0, resetn_in = 0, en = 1, ovf = 0, proh = 0, in_tx = 0, cc_en = 1;
	logic [11:0] thr = 12'h0a5;
	logic rdy = 1, req_ready, valid, taken, imp, low, ev, tracing, flag;
	req_t kind;
	exc_t exc, ee;
	isa_t isa, ei;
	logic [63:0] pc, npc, ea;
	logic [7:0] n, ec, depth, maxd, depth0, maxd0;
	elem_kind_t ek;
	logic cce, etx, flag0;
	logic [11:0] ethr;
	elem_t q[$];
	elem_t e;
	row_t rows[20];
	int fail_count = 0, n_checks = 0, cyc = 0, dep = 0;
	always #5 clk_in = ~clk_in;
	core_model #(.PC(PC), .NPC(NPC)) u_core (.clk_in(clk_in), .ready_in(req_ready),
		.valid_out(valid), .kind_out(kind), .taken_out(taken), .exc_out(exc), .imp_out(imp),
		.low_out(low), .isa_out(isa), .pc_out(pc), .npc_out(npc), .n_out(n));
	trace_element_generator u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
		.trace_enable_in(en), .buffer_overflow_in(ovf), .prohibited_in(proh),
		.in_tx_in(in_tx), .cc_enable_in(cc_en), .cc_threshold_in(thr),
		.req_valid_in(valid), .req_kind_in(kind), .req_taken_in(taken),
		.req_exc_type_in(exc), .req_imprecise_in(imp), .req_halt_low_in(low),
		.req_isa_in(isa), .req_pc_in(pc), .req_next_pc_in(npc), .exc_link_in(XLINK),
		.halt_link_in(HL), .halt_link_low_in(HLL), .req_count_in(n),
		.req_ready_out(req_ready), .elem_ready_in(rdy), .elem_valid_out(ev),
		.elem_kind_out(ek), .elem_exc_type_out(ee), .elem_isa_out(ei), .elem_addr_out(ea),
		.elem_count_out(ec), .elem_cc_en_out(cce), .elem_cc_thr_out(ethr), .elem_tx_out(etx),
		.spec_depth_out(depth), .tracing_out(tracing),
		.max_speculation_depth_field_out(maxd), .transaction_start_is_p0_flag_out(flag));
	// copy without speculation: only its fields and its pending count are watched
	trace_element_generator #(.SPEC_IMPL(1'b0)) u_dut_nospec (.clk_in(clk_in),
		.resetn_in(resetn_in), .trace_enable_in(en), .buffer_overflow_in(ovf),
		.prohibited_in(proh), .in_tx_in(in_tx), .cc_enable_in(cc_en), .cc_threshold_in(thr),
		.req_valid_in(valid), .req_kind_in(kind), .req_taken_in(taken),
		.req_exc_type_in(exc), .req_imprecise_in(imp), .req_halt_low_in(low),
		.req_isa_in(isa), .req_pc_in(pc), .req_next_pc_in(npc), .exc_link_in(XLINK),
		.halt_link_in(HL), .halt_link_low_in(HLL), .req_count_in(n), .req_ready_out(),
		.elem_ready_in(rdy), .elem_valid_out(), .elem_kind_out(), .elem_exc_type_out(),
		.elem_isa_out(), .elem_addr_out(), .elem_count_out(), .elem_cc_en_out(),
		.elem_cc_thr_out(), .elem_tx_out(), .spec_depth_out(depth0), .tracing_out(),
		.max_speculation_depth_field_out(maxd0), .transaction_start_is_p0_flag_out(flag0));
	// accepted elements, in arrival order
	always @(posedge clk_in) begin
		if (resetn_in && ev === 1'b1 && rdy)
			q.push_back('{ek, ee, ei, ea, ec, cce, ethr, etx});
	end
	// the whole run needs well under 1000 cycles
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic pop(output elem_t x);
		int w;
		w = 0;
		while (q.size() == 0 && w < 50) begin
			@(negedge clk_in);
			w++;
		end
		x = '0;
		if (q.size() == 0)
			chk(64'h0, 64'h1);
		else
			x = q.pop_front();
	endtask : pop
	initial begin
		rows = '{
			'{REQ_ATOM, EXC_IRQ, 0, 0, ISA_64, 1, 0, K_ATOM_E, PC},
			'{REQ_ATOM, EXC_IRQ, 0, 0, ISA_64, 0, 0, K_ATOM_N, PC},
			'{REQ_EXC, EXC_IRQ, 0, 0, ISA_64, 0, 0, K_EXC, NPC},
			'{REQ_EXC, EXC_FIQ, 0, 0, ISA_32F, 0, 0, K_EXC, NPC},
			'{REQ_EXC, EXC_TRAP, 0, 0, ISA_32C, 0, 0, K_EXC, PC},
			'{REQ_EXC, EXC_CALL, 0, 0, ISA_64, 0, 0, K_EXC, NPC},
			'{REQ_EXC, EXC_IFLT, 0, 0, ISA_32F, 0, 0, K_EXC, PC},
			'{REQ_EXC, EXC_DFLT, 0, 0, ISA_32C, 0, 0, K_EXC, PC},
			'{REQ_EXC, EXC_IDBG, 0, 0, ISA_64, 0, 0, K_EXC, PC},
			'{REQ_EXC, EXC_DDBG, 0, 0, ISA_32F, 0, 0, K_EXC, PC},
			'{REQ_EXC, EXC_ALIGN, 0, 0, ISA_32C, 0, 0, K_EXC, PC},
			'{REQ_EXC, EXC_SERR, 0, 0, ISA_64, 0, 0, K_EXC, NPC},
			'{REQ_EXC, EXC_SERR, 1, 0, ISA_32F, 0, 0, K_EXC, XLINK},
			'{REQ_EXC, EXC_HALT, 0, 0, ISA_32C, 0, 0, K_EXC, NPC},
			'{REQ_EXC, EXC_HALT, 1, 0, ISA_64, 0, 0, K_EXC, HL},
			'{REQ_EXC, EXC_HALT, 1, 1, ISA_32F, 0, 0, K_EXC, HLL},
			'{REQ_TXSTART, EXC_IRQ, 0, 0, ISA_64, 0, 0, K_TXSTART, 0},
			'{REQ_TXCOMMIT, EXC_IRQ, 0, 0, ISA_64, 0, 0, K_TXCOMMIT, 0},
			'{REQ_CANCEL, EXC_IRQ, 0, 0, ISA_64, 0, 8'h03, K_CANCEL, 0},
			'{REQ_COMMIT, EXC_IRQ, 0, 0, ISA_64, 0, 8'h04, K_COMMIT, 0}};
		repeat (16) @(negedge clk_in);
		chk({ev, tracing, depth, req_ready}, 0);
		chk({maxd, flag, maxd0, flag0}, {8'h10, 1'b0, 8'h00, 1'b1});
		resetn_in = 1;
		pop(e);
		chk({e.kind, e.count, e.cc_en, e.cc_thr, e.tx}, {K_INFO, 8'h0, 1'b1, 12'h0a5, 1'b0});
		//------------------------------------------------------------
		// ordinary cases: issued back to back, then compared in order
		//------------------------------------------------------------
		foreach (rows[r])
			u_core.issue(rows[r].k, rows[r].e, rows[r].imp, rows[r].low, rows[r].i, rows[r].tk,
				rows[r].n);
		u_core.idle();
		foreach (rows[r]) begin
			pop(e);
			chk(e.kind, rows[r].ek);
			if (rows[r].ek inside {K_EXC, K_ATOM_E, K_ATOM_N})
				chk(e.addr, rows[r].ea);
			if (rows[r].ek == K_EXC)
				chk({e.exc_type, e.isa}, {rows[r].e, rows[r].i});
			if (rows[r].ek inside {K_COMMIT, K_CANCEL})
				chk(e.count, rows[r].n);
			if (rows[r].ek inside {K_EXC, K_ATOM_E, K_ATOM_N})
				dep++;
			else if (rows[r].ek inside {K_COMMIT, K_CANCEL})
				dep = dep > rows[r].n ? dep - rows[r].n : 0;
		end
		chk(depth, dep);
		chk(depth0, dep + 1);
		//------------------------------------------------------------
		// awkward cases
		//------------------------------------------------------------
		// consumer stalls: element must stand and requests wait
		rdy = 0;
		u_core.issue(REQ_ATOM, EXC_IRQ, 0, 0, ISA_64, 0, 0);
		u_core.idle();
		repeat (3) @(negedge clk_in);
		chk({ev, ek, req_ready}, {1'b1, K_ATOM_N, 1'b0});
		rdy = 1;
		pop(e);
		// traced transaction cut short by overflow, then by prohibited entry
		for (int c = 0; c < 2; c++) begin
			in_tx = 1;
			u_core.issue(REQ_ATOM, EXC_IRQ, 0, 0, ISA_64, 1, 0);
			u_core.idle();
			{proh, ovf} = c ? 2'b10 : 2'b01;
			in_tx = 0;
			repeat (4) @(negedge clk_in);
			chk(req_ready, 0);
			{proh, ovf} = 2'b00;
			pop(e);
			chk(e.kind, K_ATOM_E);
			pop(e);
			chk({e.kind, e.exc_type}, {K_EXC, EXC_TXFAIL});
		end
		dep += 5;
		// disable then enable: fresh info with current depth
		en = 0;
		thr = 12'h03c;
		repeat (3) @(negedge clk_in);
		chk(tracing, 0);
		en = 1;
		pop(e);
		chk({e.kind, e.count, e.cc_thr}, {K_INFO, dep[7:0], 12'h03c});
		chk(depth, dep);
		// reset in mid-run flushes pending elements
		@(negedge clk_in);
		resetn_in = 0;
		#1;
		chk({ev, depth, tracing}, 0);
		q.delete();
		@(negedge clk_in);
		resetn_in = 1;
		pop(e);
		chk({e.kind, e.count}, {K_INFO, 8'h0});
		results();
	end
endmodule : trace_element_generator_tb
